// ==== rtl/ttm_defines.vh ====
`ifndef TTM_DEFINES_VH
`define TTM_DEFINES_VH

// ----------------------------------------------------------------
// Register indices on the model-specific register port
// ----------------------------------------------------------------
`define TTM_IDX_MISC 2'h0
`define TTM_IDX_STAT 2'h1
`define TTM_IDX_IEN 2'h2
`define TTM_IDX_VENT 2'h3

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TTM_MISC_TM_EN_BIT 3
`define TTM_STAT_HOT_BIT 0
`define TTM_STAT_LOG_BIT 1
`define TTM_IEN_HI_BIT 0
`define TTM_IEN_LO_BIT 1
`define TTM_VENT_VEC_LSB 0
`define TTM_VENT_VEC_MSB 7
`define TTM_VENT_MODE_LSB 8
`define TTM_VENT_MODE_MSB 10
`define TTM_VENT_MASK_BIT 16

// ----------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------
`define TTM_MISC_RESET 64'h0000000000000000
`define TTM_IEN_RESET 2'h0
`define TTM_VENT_RESET 32'h00010000
`define TTM_VENT_WMASK 32'h000107FF

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define TTM_CLK_MHZ 32'h32
`define TTM_HOLD_US 32'h3E8
`define TTM_HOLD_CYC (`TTM_HOLD_US * `TTM_CLK_MHZ)
`define TTM_DUTY_PERIOD 8'h10
`define TTM_DUTY_ON 8'h08

`endif

// ==== rtl/ttm_duty_gen.v ====
`timescale 1ns/1ps
`include "ttm_defines.vh"

module ttm_duty_gen #(
  parameter [7:0] PERIOD = `TTM_DUTY_PERIOD,
  parameter [7:0] ON_CYC = `TTM_DUTY_ON
) (
  input wire mclk, // Core clock
  input wire sys_rst, // Synchronous reset, high
  input wire modEn, // Modulation requested
  output reg gateOpen_q // Clock allowed to reach the core
);

  reg [7:0] phase_q;

  // ----------------------------------------------------------------
  // Stop-clock window: open for ON_CYC of every PERIOD cycles
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    if (sys_rst) begin
      phase_q <= 8'h00;
      gateOpen_q <= 1'b1;
    end else if (!modEn) begin
      phase_q <= 8'h00;
      gateOpen_q <= 1'b1;
    end else begin
      if (phase_q == PERIOD - 8'h01) begin
        phase_q <= 8'h00;
      end else begin
        phase_q <= phase_q + 8'h01;
      end
      gateOpen_q <= (phase_q < ON_CYC);
    end
  end

endmodule

// ==== rtl/ttm_thermal_monitor.v ====
// Notes on behaviour
// - Catastrophic trip halts execution until reset; never disabled.
// - Throttling uses stop-clock gating to hold a nominal core duty.
// - Duty is the share of time the clock reaches the core.
// - Throttling is internal; the external clock-stop pin plays no part.
// - Throttling only when misc enable bit 3 is set; reset clears it.
// - Read-only hot bit shows above-trip and throttling; clear otherwise.
// - Sticky log bit sets on every trip; cleared by software or reset.
// - After a trip hold 50 percent duty for at least 1 ms and until cool.
// - Stopped-clock cycles block interrupt delivery; requests stay pending.
// - High-temperature enable raises interrupt on a below-to-above crossing.
// - Low-temperature enable raises interrupt on an above-to-below crossing.
// - Thermal vector entry gives mode, mask and vector; mask suppresses it.
// - Reset clears both interrupt enables and masks the vector entry.
// - Throttling never changes the time stamp counter rate.
`timescale 1ns/1ps
`include "ttm_defines.vh"

module ttm_thermal_monitor #(
  parameter [31:0] HOLD_CYCLES = `TTM_HOLD_CYC,
  parameter [7:0] DUTY_PERIOD = `TTM_DUTY_PERIOD,
  parameter [7:0] DUTY_ON = `TTM_DUTY_ON
) (
  input wire mclk, // Core clock, 50 MHz
  input wire sys_rst, // Synchronous reset, high
  input wire catTripPin, // Catastrophic sensor trip, async
  input wire tmTripPin, // Thermal monitor sensor trip, async
  input wire msrWr, // Register write strobe
  input wire msrRd, // Register read strobe
  input wire [1:0] msrIdx, // Register index
  input wire [63:0] msrWdata, // Register write data
  output reg [63:0] msrRdata_q, // Register read data
  output reg msrRdValid_q, // Read data valid pulse
  input wire irqAck, // Interrupt taken by the controller
  output reg irqValid_q, // Thermal interrupt offered
  output reg [7:0] irqVector_q, // Interrupt vector
  output reg [2:0] irqMode_q, // Delivery mode
  output reg coreClkEn_q, // Core clock gate
  output reg coreHalt_q, // Execution halted
  output reg throttleActive_q, // Monitor is modulating
  output reg [63:0] tscCount_q // Time stamp counter
);

  localparam ST_IDLE = 1'b0;
  localparam ST_THROT = 1'b1;

  reg catMeta_q, catSync_q, tmMeta_q, tmSync_q, tmPrev_q;
  reg catHalt_q;
  reg tmEnable;
  reg [63:0] miscReg_q;
  reg [1:0] irqEn_q;
  reg [31:0] ventry_q;
  reg logBit_q;
  reg state_q, state_d;
  reg [31:0] holdCnt_q;
  reg pending_q;
  wire gateOpen;
  wire hotRise, hotFall, holdDone, wrMisc, wrStat, wrIen, wrVent;
  wire irqSet, delivered, irqMasked;
  wire [63:0] statWord;

  // ----------------------------------------------------------------
  // Trip input synchronisers
  // ----------------------------------------------------------------
  // Two flops each, plus tmPrev_q for edge detection; the first flop feeds only the second
  always @(posedge mclk) begin
    if (sys_rst) begin
      catMeta_q <= 1'b0;
      catSync_q <= 1'b0;
      tmMeta_q <= 1'b0;
      tmSync_q <= 1'b0;
      tmPrev_q <= 1'b0;
    end else begin
      catMeta_q <= catTripPin;
      catSync_q <= catMeta_q;
      tmMeta_q <= tmTripPin;
      tmSync_q <= tmMeta_q;
      tmPrev_q <= tmSync_q;
    end
  end

  assign hotRise = tmSync_q & ~tmPrev_q;
  assign hotFall = ~tmSync_q & tmPrev_q;

  // ----------------------------------------------------------------
  // Catastrophic shutdown
  // ----------------------------------------------------------------
  // No enable gates this path; only reset releases the halt
  always @(posedge mclk) begin
    if (sys_rst) begin
      catHalt_q <= 1'b0;
    end else if (catSync_q) begin
      catHalt_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  assign wrMisc = msrWr && (msrIdx == `TTM_IDX_MISC);
  assign wrStat = msrWr && (msrIdx == `TTM_IDX_STAT);
  assign wrIen = msrWr && (msrIdx == `TTM_IDX_IEN);
  assign wrVent = msrWr && (msrIdx == `TTM_IDX_VENT);

  // Enables and vector entry
  always @(posedge mclk) begin
    if (sys_rst) begin
      miscReg_q <= `TTM_MISC_RESET;
      irqEn_q <= `TTM_IEN_RESET;
      ventry_q <= `TTM_VENT_RESET;
    end else begin
      if (wrMisc) begin
        miscReg_q <= msrWdata;
      end
      if (wrIen) begin
        irqEn_q <= msrWdata[1:0];
      end
      if (wrVent) begin
        ventry_q <= msrWdata[31:0] & `TTM_VENT_WMASK;
      end
    end
  end

  always @* begin
    tmEnable = miscReg_q[`TTM_MISC_TM_EN_BIT];
  end

  // Sticky log; a trip in the clearing cycle wins
  always @(posedge mclk) begin
    if (sys_rst) begin
      logBit_q <= 1'b0;
    end else if (hotRise) begin
      logBit_q <= 1'b1;
    end else if (wrStat && !msrWdata[`TTM_STAT_LOG_BIT]) begin
      logBit_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Throttle control
  // ----------------------------------------------------------------
  assign holdDone = (holdCnt_q >= HOLD_CYCLES - 32'h1);

  // Leave once the hold time has run out and the sensor is cool, or at once when the enable is cleared
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (tmEnable && tmSync_q) begin
          state_d = ST_THROT;
        end
      end
      ST_THROT: begin
        if (!tmEnable) begin
          state_d = ST_IDLE;
        end else if (holdDone && !tmSync_q) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // State and minimum hold timer; a fresh trip restarts the timer
  always @(posedge mclk) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      holdCnt_q <= 32'h0;
    end else begin
      state_q <= state_d;
      if (state_q != ST_THROT || hotRise) begin
        holdCnt_q <= 32'h0;
      end else if (!holdDone) begin
        holdCnt_q <= holdCnt_q + 32'h1;
      end
    end
  end

  // Internal stop-clock; no external pin is involved
  ttm_duty_gen #(
    .PERIOD(DUTY_PERIOD),
    .ON_CYC(DUTY_ON)
  ) u_duty (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .modEn(state_d == ST_THROT),
    .gateOpen_q(gateOpen)
  );

  // Core gate, halt and throttle flags
  always @(posedge mclk) begin
    if (sys_rst) begin
      coreClkEn_q <= 1'b1;
      coreHalt_q <= 1'b0;
      throttleActive_q <= 1'b0;
    end else begin
      coreClkEn_q <= gateOpen & ~catHalt_q;
      coreHalt_q <= catHalt_q | catSync_q;
      throttleActive_q <= (state_q == ST_THROT);
    end
  end

  // ----------------------------------------------------------------
  // Thermal interrupt
  // ----------------------------------------------------------------
  assign irqMasked = ventry_q[`TTM_VENT_MASK_BIT];
  assign irqSet = ~irqMasked &
    ((hotRise & irqEn_q[`TTM_IEN_HI_BIT]) |
     (hotFall & irqEn_q[`TTM_IEN_LO_BIT]));
  assign delivered = irqValid_q & irqAck;

  // Pending request survives stopped-clock windows; new set wins
  always @(posedge mclk) begin
    if (sys_rst) begin
      pending_q <= 1'b0;
      irqValid_q <= 1'b0;
      irqVector_q <= 8'h00;
      irqMode_q <= 3'h0;
    end else begin
      pending_q <= irqSet | (pending_q & ~delivered);
      irqValid_q <= pending_q & ~delivered & gateOpen & ~catHalt_q;
      irqVector_q <= ventry_q[`TTM_VENT_VEC_MSB:`TTM_VENT_VEC_LSB];
      irqMode_q <= ventry_q[`TTM_VENT_MODE_MSB:`TTM_VENT_MODE_LSB];
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  assign statWord = {62'h0, logBit_q,
    tmSync_q & (state_q == ST_THROT)};

  always @(posedge mclk) begin
    if (sys_rst) begin
      msrRdata_q <= 64'h0;
      msrRdValid_q <= 1'b0;
    end else begin
      msrRdValid_q <= msrRd;
      if (msrRd) begin
        case (msrIdx)
          `TTM_IDX_MISC: msrRdata_q <= miscReg_q;
          `TTM_IDX_STAT: msrRdata_q <= statWord;
          `TTM_IDX_IEN: msrRdata_q <= {62'h0, irqEn_q};
          `TTM_IDX_VENT: msrRdata_q <= {32'h0, ventry_q};
          default: msrRdata_q <= 64'h0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Time stamp counter on the ungated core clock
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    if (sys_rst) begin
      tscCount_q <= 64'h0;
    end else begin
      tscCount_q <= tscCount_q + 64'h1;
    end
  end

endmodule

// ==== bench/ttm_props.sv ====
`timescale 1ns/1ps
// ------------------------------------------------
// Port checker for the thermal monitor
// ------------------------------------------------
module ttm_props (
  input logic mclk, // Core clock
  input logic sys_rst, // Sync reset
  input logic msrRd, // Read strobe
  input logic irqAck, // Interrupt taken
  input logic msrRdValid_q, // Read valid
  input logic irqValid_q, // Interrupt offered
  input logic coreClkEn_q, // Core clock gate
  input logic coreHalt_q, // Halted
  input logic throttleActive_q, // Throttling
  input logic [63:0] tscCount_q // Time stamp
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // Counter keeps its full rate whatever the gate does
  chk_tsc_free_run: assert property (
    !$past(sys_rst) |-> tscCount_q == $past(tscCount_q) + 64'h1)
    else $error("time stamp skipped");
  chk_read_valid: assert property (msrRdValid_q == $past(msrRd))
    else $error("read valid misplaced");
  chk_halt_sticky: assert property (
    coreHalt_q |=> coreHalt_q) else $error("halt released");
  chk_halt_gates: assert property (
    coreHalt_q |=> !coreClkEn_q) else $error("clock runs in halt");
  chk_halt_no_irq: assert property (
    coreHalt_q && $past(coreHalt_q) |-> !irqValid_q)
    else $error("interrupt while halted");
  // Gate is open once throttling has been gone for a while
  chk_idle_clock: assert property (
    !throttleActive_q && !$past(throttleActive_q) &&
    !$past(throttleActive_q, 2) && !coreHalt_q |-> coreClkEn_q)
    else $error("clock gated while idle");
  // Closed phase lasts exactly eight cycles
  chk_duty_closed: assert property (
    $fell(coreClkEn_q) && throttleActive_q |->
    (!coreClkEn_q || !throttleActive_q)[*8] ##1
    (coreClkEn_q || !throttleActive_q || coreHalt_q))
    else $error("closed phase length wrong");
  chk_irq_held: assert property (
    irqValid_q && !irqAck && !throttleActive_q && !coreHalt_q |=>
    irqValid_q) else $error("interrupt lost");
  chk_irq_acked: assert property (
    irqValid_q && irqAck |=> !irqValid_q) else $error("ack ignored");
  cover property (irqValid_q && irqAck);
  cover property ($fell(coreClkEn_q) && throttleActive_q);
  cover property ($rose(coreHalt_q));
endmodule

// ==== bench/ttm_sensor_model.sv ====
`timescale 1ns/1ps
// ------------------------------------------------
// Temperature sensors and interrupt controller
// ------------------------------------------------
module ttm_sensor_model (
  input logic mclk, // Core clock
  input logic irqValid_q, // Interrupt offered
  input logic hot, // Die above monitor trip
  input logic burn, // Die above catastrophic trip
  input logic [3:0] ackWait, // Cycles before taking interrupt
  output logic tmTripPin, // Monitor trip
  output logic catTripPin, // Catastrophic trip
  output logic irqAck // Interrupt taken
);
  logic [3:0] waitCnt;
  // Pins follow the die levels, which move just after the clock edge
  assign tmTripPin = hot;
  assign catTripPin = burn;
  // Controller takes the offer after ackWait cycles
  initial begin
    irqAck = 1'b0;
    waitCnt = 4'h0;
  end
  always @(posedge mclk) begin
    #1;
    irqAck = 1'b0;
    if (irqValid_q !== 1'b1) begin
      waitCnt = 4'h0;
    end else if (waitCnt == ackWait) begin
      irqAck = 1'b1;
      waitCnt = 4'h0;
    end else begin
      waitCnt = waitCnt + 4'h1;
    end
  end
endmodule

// ==== bench/tb.sv ====
`timescale 1ns/1ps
module tb;
  logic mclk, sys_rst, msrWr, msrRd, irqAck, tmTripPin, catTripPin;
  logic hot, burn, irqValid_q, msrRdValid_q, coreClkEn_q, coreHalt_q;
  logic throttleActive_q, seen;
  logic [1:0] msrIdx;
  logic [2:0] irqMode_q;
  logic [7:0] irqVector_q;
  logic [3:0] ackWait;
  logic [63:0] msrWdata, msrRdata_q, tscCount_q, t0, ones;
  int bad_count, comparisons, n;
  ttm_thermal_monitor #(.HOLD_CYCLES(32'h14)) ttm_thermal_monitor_i (
    .mclk, .sys_rst, .catTripPin, .tmTripPin, .msrWr, .msrRd, .msrIdx,
    .msrWdata, .msrRdata_q, .msrRdValid_q, .irqAck, .irqValid_q,
    .irqVector_q, .irqMode_q, .coreClkEn_q, .coreHalt_q,
    .throttleActive_q, .tscCount_q);
  ttm_sensor_model ttm_sensor_model_i (.mclk, .irqValid_q, .hot, .burn,
    .ackWait, .tmTripPin, .catTripPin, .irqAck);
  // ------------------------------------------------
  // Helpers
  // ------------------------------------------------
  task tick;
    @(posedge mclk);
    #1;
  endtask
  task chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task wr(input logic [1:0] idx, input logic [63:0] d);
    msrWr = 1'b1;
    msrIdx = idx;
    msrWdata = d;
    tick;
    msrWr = 1'b0;
    tick;
  endtask
  task rdChk(input logic [1:0] idx, input logic [63:0] exp);
    msrRd = 1'b1;
    msrIdx = idx;
    tick;
    msrRd = 1'b0;
    chk(msrRdValid_q, 64'h1);
    chk(msrRdata_q, exp);
    tick;
  endtask
  task doReset;
    sys_rst = 1'b1;
    repeat (5) @(posedge mclk);
    #1 sys_rst = 1'b0;
  endtask
  task stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ------------------------------------------------
  // Scenarios
  // ------------------------------------------------
  task resetVals;
    rdChk(2'h0, 64'h0);
    rdChk(2'h1, 64'h0);
    rdChk(2'h2, 64'h0);
    rdChk(2'h3, 64'h10000);
  endtask
  task regAccess;
    wr(2'h0, '1);
    rdChk(2'h0, '1);
    wr(2'h1, '1);
    rdChk(2'h1, 64'h0);
    wr(2'h3, '1);
    rdChk(2'h3, 64'h107FF);
    wr(2'h0, 64'h0);
  endtask
  task maskedTrip;
    ackWait = 4'h0;
    wr(2'h2, 64'h3);
    wr(2'h3, 64'h10203);
    hot = 1'b1;
    seen = 1'b0;
    repeat (30) begin
      tick;
      seen = seen | irqValid_q | throttleActive_q;
    end
    chk(seen, 64'h0);
    rdChk(2'h1, 64'h2);
    hot = 1'b0;
    repeat (5) tick;
  endtask
  task throttleRun;
    ackWait = 4'h3;
    wr(2'h3, 64'h203);
    wr(2'h0, 64'h8);
    hot = 1'b1;
    for (n = 0; n < 40 && irqValid_q !== 1'b1; n++) tick;
    chk(throttleActive_q, 64'h1);
    chk({irqMode_q, irqVector_q}, 64'h203);
    t0 = tscCount_q;
    ones = 0;
    repeat (32) begin
      tick;
      ones += coreClkEn_q;
    end
    chk(ones, 64'h10);
    chk(tscCount_q - t0, 64'h20);
    rdChk(2'h1, 64'h3);
    hot = 1'b0;
    for (n = 0; n < 60 && irqValid_q !== 1'b1; n++) tick;
    chk(irqValid_q, 64'h1);
    for (n = 0; n < 60 && throttleActive_q !== 1'b0; n++) tick;
    chk(throttleActive_q, 64'h0);
    rdChk(2'h1, 64'h2);
    wr(2'h1, 64'h0);
    rdChk(2'h1, 64'h0);
  endtask
  // Short trip: throttle must stay for the whole hold time counted from throttle entry
  task briefTrip;
    ones = 0;
    hot = 1'b1;
    for (n = 0; n < 44; n++) begin
      tick;
      ones += throttleActive_q;
      if (n == 3) hot = 1'b0;
    end
    chk(ones, 64'h14);
  endtask
  task meltdown;
    burn = 1'b1;
    for (n = 0; n < 10 && coreHalt_q !== 1'b1; n++) tick;
    burn = 1'b0;
    repeat (10) tick;
    chk({coreHalt_q, coreClkEn_q}, 64'h2);
    doReset;
    chk(coreHalt_q, 64'h0);
    resetVals;
  endtask
  // ------------------------------------------------
  // Clock, watchdog and main sequence
  // ------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial begin
    #100000;
    bad_count++;
    stop_test;
  end
  initial begin
    {sys_rst, msrWr, msrRd, hot, burn, msrIdx} = '0;
    msrWdata = 64'h0;
    ackWait = 4'h0;
    bad_count = 0;
    comparisons = 0;
    doReset;
    resetVals;
    regAccess;
    maskedTrip;
    throttleRun;
    briefTrip;
    meltdown;
    stop_test;
  end
endmodule
bind ttm_thermal_monitor ttm_props ttm_props_i (.mclk, .sys_rst, .msrRd,
  .irqAck, .msrRdValid_q, .irqValid_q, .coreClkEn_q, .coreHalt_q,
  .throttleActive_q, .tscCount_q);
